//--- rtl/timer_counter_pwm_unit_unit.sv
/*
 * Timer, counter and PWM unit with an AXI4-Lite register slave, capture input,
 * dead-band complementary outputs, kill override and one masked interrupt.
 * Assumes the capture and kill pins are asynchronous to i_ref_clk.
 */
`timescale 1ns/100ps
// Notes on behaviour
// [RL1] 16-bit counter, period set by software.
// [RL2] Capture event copies counter into capture register.
// [RL3] At period, halt or reload per configuration.
// [RL4] Compare values set the PWM duty cycle.
// [RL5] True and complement outputs with dead-band.
// [RL6] Kill forces outputs to configured state.
// [RL7] Kill acts in hardware, no software.
// [RL8] Flags for terminal count, compare, capture.
module timer_counter_pwm_unit_unit
	import timer_counter_pwm_unit_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_ce,
	input wire logic i_capture,
	input wire logic i_kill,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic o_pwm,
	output logic o_pwm_n,
	output logic o_irq
);
	typedef struct packed {
		logic [5:0] ctrl;
		logic [15:0] period;
		logic [15:0] cmp0;
		logic [15:0] cmp1;
		logic [7:0] dead;
		logic [15:0] count;
		logic [15:0] capt;
		logic [TCP_ST_W-1:0] stat;
		logic [TCP_ST_W-1:0] mask;
		logic [2:0] cap_sync;
		logic [2:0] kill_sync;
		logic cap_lvl;
		logic kill_lvl;
		logic running;
		logic pwm;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic out_t;
		logic out_c;
		logic irq;
		logic aw_rdy;
		logic w_rdy;
		logic ar_rdy;
	} timer_counter_pwm_unit_unit_t;

	timer_counter_pwm_unit_unit_t r;
	timer_counter_pwm_unit_unit_t next_r;
	logic dead_true;
	logic dead_comp;

	// Dead-band stage sits between the compare level and the output override.
	timer_counter_pwm_unit_dead u_dead (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_ce(i_ce),
		.i_pwm(r.pwm),
		.i_dead(r.dead),
		.o_true(dead_true),
		.o_comp(dead_comp)
	);

	// Merges a write with byte strobes into a 16-bit register.
	function automatic logic [15:0] tcp_merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [15:0] v;
		v = old;
		if (s[0]) begin
			v[7:0] = d[7:0];
		end
		if (s[1]) begin
			v[15:8] = d[15:8];
		end
		return v;
	endfunction

	// All behaviour except the dead-band: synchronisers, counter, compare, kill override, bus slave, flags.
	always_comb begin
		logic cap_evt;
		logic tc_evt;
		logic cmp_evt;
		logic kill_evt;
		logic do_wr;
		logic do_rd;
		logic wr_ok;
		logic clr_stat;
		logic [TCP_ST_W-1:0] set_stat;
		cap_evt = 1'b0;
		tc_evt = 1'b0;
		cmp_evt = 1'b0;
		kill_evt = 1'b0;
		do_wr = 1'b0;
		do_rd = 1'b0;
		wr_ok = 1'b1;
		clr_stat = 1'b0;
		set_stat = '0;
		next_r = r;
		next_r.ctrl[TCP_CTRL_START] = 1'b0;

		// Three-stage synchronisers; a change counts once stages two and three agree.
		next_r.cap_sync = {r.cap_sync[1:0], i_capture};
		next_r.kill_sync = {r.kill_sync[1:0], i_kill};
		if (r.cap_sync[1] == r.cap_sync[2]) begin
			next_r.cap_lvl = r.cap_sync[2];
		end
		if (r.kill_sync[1] == r.kill_sync[2]) begin
			next_r.kill_lvl = r.kill_sync[2];
		end
		cap_evt = next_r.cap_lvl & ~r.cap_lvl & r.ctrl[TCP_CTRL_CAPT_EN];
		kill_evt = next_r.kill_lvl & ~r.kill_lvl;

		// Capture takes the counter as it stands in the event cycle.
		if (cap_evt) begin
			next_r.capt = r.count; // see [RL2]
		end

		// Counter: clear when disabled, restart on a start pulse, wrap or halt at period.
		// A start pulse while already running is ignored, so a stray write of the start bit
		// cannot shorten a period that the power stage is already using.
		if (!r.ctrl[TCP_CTRL_EN]) begin
			next_r.count = TCP_ZERO16;
			next_r.running = 1'b0;
		end else begin
			if (r.ctrl[TCP_CTRL_START] && !r.running) begin
				next_r.running = 1'b1;
				next_r.count = TCP_ZERO16;
			end else if (r.running) begin
				if (r.count == r.period) begin
					tc_evt = 1'b1;
					next_r.count = TCP_ZERO16; // see [RL3]
					if (r.ctrl[TCP_CTRL_ONESHOT]) begin
						next_r.running = 1'b0; // see [RL3]
						next_r.count = r.count;
					end
				end else begin
					next_r.count = r.count + 16'h0001; // see [RL1]
				end
			end
		end

		// PWM is high from compare 0 up to but not including compare 1.
		if (r.running && r.count == r.cmp0) begin
			next_r.pwm = 1'b1; // see [RL4]
			cmp_evt = 1'b1;
		end else if (r.count == r.cmp1 || !r.running) begin
			next_r.pwm = 1'b0; // see [RL4]
		end
		if (r.running && r.count == r.cmp1) begin
			cmp_evt = 1'b1;
		end

		// Kill overrides the outputs straight from the synchronised pin, no software path.
		// The cost is a few cycles of synchroniser latency, traded for immunity to
		// metastability on a pin that may come straight from an analog comparator.
		if (next_r.kill_lvl) begin
			next_r.out_t = r.ctrl[TCP_CTRL_KILL_LVL]; // see [RL6] [RL7]
			next_r.out_c = r.ctrl[TCP_CTRL_KILL_LVL_N]; // see [RL6] [RL7]
		end else begin
			next_r.out_t = dead_true; // see [RL5]
			next_r.out_c = dead_comp; // see [RL5]
		end

		// Write channel: address and data are held independently, response follows both.
		// A write to a read-only register is accepted and dropped; only unmapped places
		// answer with an error, so software probing the map can tell the two apart.
		if (i_awvalid && !r.aw_held) begin
			next_r.aw_held = 1'b1;
			next_r.aw_addr = i_awaddr;
		end
		if (i_wvalid && !r.w_held) begin
			next_r.w_held = 1'b1;
			next_r.w_data = i_wdata;
			next_r.w_strb = i_wstrb;
		end
		if (r.bvalid && i_bready) begin
			next_r.bvalid = 1'b0;
		end
		do_wr = r.aw_held && r.w_held && !r.bvalid;
		if (do_wr) begin
			next_r.aw_held = 1'b0;
			next_r.w_held = 1'b0;
			next_r.bvalid = 1'b1;
			case (r.aw_addr)
				TCP_CTRL_OFS: begin
					if (r.w_strb[0]) begin
						next_r.ctrl = r.w_data[5:0];
					end
				end
				TCP_PERIOD_OFS: next_r.period = tcp_merge16(r.period, r.w_data, r.w_strb);
				TCP_CMP0_OFS: next_r.cmp0 = tcp_merge16(r.cmp0, r.w_data, r.w_strb);
				TCP_CMP1_OFS: next_r.cmp1 = tcp_merge16(r.cmp1, r.w_data, r.w_strb);
				TCP_DEAD_OFS: begin
					if (r.w_strb[0]) begin
						next_r.dead = r.w_data[7:0];
					end
				end
				TCP_MASK_OFS: begin
					if (r.w_strb[0]) begin
						next_r.mask = r.w_data[TCP_ST_W-1:0];
					end
				end
				TCP_COUNT_OFS, TCP_CAPT_OFS, TCP_STAT_OFS: wr_ok = 1'b1;
				default: wr_ok = 1'b0;
			endcase
			next_r.bresp = wr_ok ? TCP_RESP_OKAY : TCP_RESP_SLVERR;
		end

		// Read channel: one-cycle accept, data registered, held until rready.
		if (r.rvalid && i_rready) begin
			next_r.rvalid = 1'b0;
		end
		do_rd = i_arvalid && !r.rvalid;
		if (do_rd) begin
			next_r.rvalid = 1'b1;
			next_r.rresp = TCP_RESP_OKAY;
			next_r.rdata = '0;
			case (i_araddr)
				TCP_CTRL_OFS: next_r.rdata[5:0] = r.ctrl;
				TCP_PERIOD_OFS: next_r.rdata[15:0] = r.period;
				TCP_CMP0_OFS: next_r.rdata[15:0] = r.cmp0;
				TCP_CMP1_OFS: next_r.rdata[15:0] = r.cmp1;
				TCP_DEAD_OFS: next_r.rdata[7:0] = r.dead;
				TCP_COUNT_OFS: next_r.rdata[15:0] = r.count;
				TCP_CAPT_OFS: next_r.rdata[15:0] = r.capt;
				TCP_STAT_OFS: begin
					next_r.rdata[TCP_ST_W-1:0] = r.stat;
					clr_stat = 1'b1;
				end
				TCP_MASK_OFS: next_r.rdata[TCP_ST_W-1:0] = r.mask;
				default: next_r.rresp = TCP_RESP_SLVERR;
			endcase
		end

		// Sticky flags: a read clears them, but an event in that same cycle survives.
		set_stat[TCP_ST_TC] = tc_evt; // see [RL8]
		set_stat[TCP_ST_CMP] = cmp_evt; // see [RL8]
		set_stat[TCP_ST_CAPT] = cap_evt; // see [RL8]
		set_stat[TCP_ST_KILL] = kill_evt;
		next_r.stat = (clr_stat ? '0 : r.stat) | set_stat;
		next_r.irq = |(next_r.stat & r.mask);

		// Readies are registered copies of the next holding state, so they match it exactly.
		next_r.aw_rdy = ~next_r.aw_held;
		next_r.w_rdy = ~next_r.w_held;
		next_r.ar_rdy = ~next_r.rvalid;
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			r <= '0;
			r.ctrl <= TCP_CTRL_RST;
			r.period <= TCP_PERIOD_RST;
			r.dead <= TCP_DEAD_RST;
			r.aw_rdy <= 1'b1;
			r.w_rdy <= 1'b1;
			r.ar_rdy <= 1'b1;
		end else if (i_ce) begin
			r <= next_r;
		end
	end

	// Every output is a flop of its own; no gate sits between a register and a pin,
	// so the bus master sees no combinational path from its own requests.
	assign o_awready = r.aw_rdy;
	assign o_wready = r.w_rdy;
	assign o_bvalid = r.bvalid;
	assign o_bresp = r.bresp;
	assign o_arready = r.ar_rdy;
	assign o_rvalid = r.rvalid;
	assign o_rdata = r.rdata;
	assign o_rresp = r.rresp;
	assign o_pwm = r.out_t;
	assign o_pwm_n = r.out_c;
	assign o_irq = r.irq;
endmodule

//--- rtl/timer_counter_pwm_unit_pkg.sv
/*
 * Package for the timer, counter and PWM unit: register offsets, field positions,
 * reset values and the AXI4-Lite response codes.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package timer_counter_pwm_unit_pkg;
	localparam int TCP_CNT_W = 16;
	localparam int TCP_AW = 8;
	// Register byte offsets.
	localparam logic [7:0] TCP_CTRL_OFS = 8'h00;
	localparam logic [7:0] TCP_PERIOD_OFS = 8'h04;
	localparam logic [7:0] TCP_CMP0_OFS = 8'h08;
	localparam logic [7:0] TCP_CMP1_OFS = 8'h0C;
	localparam logic [7:0] TCP_DEAD_OFS = 8'h10;
	localparam logic [7:0] TCP_COUNT_OFS = 8'h14;
	localparam logic [7:0] TCP_CAPT_OFS = 8'h18;
	localparam logic [7:0] TCP_STAT_OFS = 8'h1C;
	localparam logic [7:0] TCP_MASK_OFS = 8'h20;
	// Control register fields.
	localparam int TCP_CTRL_EN = 0;
	localparam int TCP_CTRL_ONESHOT = 1;
	localparam int TCP_CTRL_KILL_LVL = 2;
	localparam int TCP_CTRL_KILL_LVL_N = 3;
	localparam int TCP_CTRL_CAPT_EN = 4;
	localparam int TCP_CTRL_START = 5;
	// Status bits.
	localparam int TCP_ST_TC = 0;
	localparam int TCP_ST_CMP = 1;
	localparam int TCP_ST_CAPT = 2;
	localparam int TCP_ST_KILL = 3;
	localparam int TCP_ST_W = 4;
	// Reset values.
	localparam logic [5:0] TCP_CTRL_RST = 6'h00;
	localparam logic [15:0] TCP_PERIOD_RST = 16'hFFFF;
	localparam logic [15:0] TCP_ZERO16 = 16'h0000;
	localparam logic [7:0] TCP_DEAD_RST = 8'h00;
	// AXI responses.
	localparam logic [1:0] TCP_RESP_OKAY = 2'b00;
	localparam logic [1:0] TCP_RESP_SLVERR = 2'b10;
endpackage

//--- rtl/timer_counter_pwm_unit_dead.sv
/*
 * Dead-band generator: produces true and complementary drives from one PWM level,
 * delaying each rising edge by a programmable number of cycles.
 * Assumes a single clock shared with the main unit and a clock enable.
 */
`timescale 1ns/100ps
module timer_counter_pwm_unit_dead
	import timer_counter_pwm_unit_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_ce,
	input wire logic i_pwm,
	input wire logic [7:0] i_dead,
	output logic o_true,
	output logic o_comp
);
	typedef struct packed {
		logic last;
		logic [7:0] cnt;
		logic tr;
		logic cp;
	} timer_counter_pwm_unit_dead_t;

	timer_counter_pwm_unit_dead_t r;
	timer_counter_pwm_unit_dead_t next_r;

	// Every PWM edge restarts the gap; the newly active side waits for the count to run out.
	always_comb begin
		next_r = r;
		next_r.last = i_pwm;
		if (i_pwm != r.last) begin
			next_r.cnt = i_dead;
			next_r.tr = 1'b0;
			next_r.cp = 1'b0;
		end else if (r.cnt != 8'h00) begin
			next_r.cnt = r.cnt - 8'h01;
		end else begin
			next_r.tr = i_pwm; // see [RL5]
			next_r.cp = ~i_pwm; // see [RL5]
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			r <= '0;
		end else if (i_ce) begin
			r <= next_r;
		end
	end

	assign o_true = r.tr;
	assign o_comp = r.cp;
endmodule

//--- tb/timer_counter_pwm_unit_checker.sv
/* Checker for the PWM unit ports: bus handshakes, dead-band and kill hold.
   Assumes it is bound into timer_counter_pwm_unit_unit and the bus is idle while the clock enable is low. */
`timescale 1ns/100ps
module timer_counter_pwm_unit_checker (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_kill,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic [1:0] o_bresp,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic [31:0] o_rdata,
	input wire logic o_rvalid,
	input wire logic i_rready,
	input wire logic o_pwm,
	input wire logic o_pwm_n
);
	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_resetn);
	// Eight cycles cover the kill synchroniser, so the pins are frozen by then.
	kill_hold_a: assert property (
		i_kill [*8] |-> $stable(o_pwm) && $stable(o_pwm_n)) else $error("pins move under kill");
	dead_band_a: assert property (
		!i_kill [*8] |-> !(o_pwm && o_pwm_n)) else $error("both drives high");
	aw_block_a: assert property (
		i_awvalid && o_awready |=> !o_awready) else $error("second address taken");
	b_after_a: assert property (
		$rose(o_bvalid) |-> $past(!o_awready)) else $error("response without a held write");
	b_done_a: assert property (
		o_bvalid && i_bready |=> !o_bvalid) else $error("response repeated after handshake");
	r_answer_a: assert property (
		i_arvalid && o_arready |=> o_rvalid) else $error("read answer late");
	r_done_a: assert property (
		o_rvalid && i_rready |=> !o_rvalid) else $error("read answer repeated after handshake");
	ar_block_a: assert property (
		o_rvalid |-> !o_arready) else $error("address taken during answer");
endmodule

//--- tb/timer_counter_pwm_unit_stage.sv
/* Model of the power stage driven by the PWM pins.
   Assumes one clock; the trip input stands for an over-current event. */
`timescale 1ns/100ps
module timer_counter_pwm_unit_stage (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_hi,
	input wire logic i_lo,
	input wire logic i_trip,
	output logic o_fault,
	output logic o_shoot
);
	// The comparator answers at once, since the shutdown path has no slack.
	assign o_fault = i_trip;
	// Both gates on together would short the supply, so it is remembered.
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_shoot <= 1'b0;
		end else begin
			o_shoot <= o_shoot | (i_hi & i_lo);
		end
	end
endmodule

//--- tb/testbench.sv
/* Directed testbench for the PWM unit over AXI4-Lite.
   Assumes the package, unit, checker and stage model are compiled first. */
`timescale 1ns/100ps
module testbench;
	import timer_counter_pwm_unit_pkg::*;
	localparam int PER = 9, C0 = 2, C1 = 6, DB = 1;
	localparam int TH = C1 - C0 - DB - 1, CH = PER + 1 - C1 + C0 - DB - 1;
	logic i_ref_clk = 1'b0, i_resetn = 1'b0, i_ce = 1'b1, i_capture = 1'b0;
	logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
	logic i_arvalid = 1'b0, i_rready = 1'b0, trip = 1'b0;
	logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
	logic [31:0] i_wdata = 32'h0000_0000;
	logic [3:0] i_wstrb = 4'hF;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic o_pwm, o_pwm_n, o_irq, i_kill, shoot;
	logic [1:0] o_bresp, o_rresp;
	logic [1:0] held;
	logic [31:0] o_rdata;
	int fail_count = 0;
	int total_checks = 0;

	timer_counter_pwm_unit_unit dut (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_ce(i_ce),
		.i_capture(i_capture),
		.i_kill(i_kill),
		.i_awaddr(i_awaddr),
		.i_awvalid(i_awvalid),
		.o_awready(o_awready),
		.i_wdata(i_wdata),
		.i_wstrb(i_wstrb),
		.i_wvalid(i_wvalid),
		.o_wready(o_wready),
		.o_bresp(o_bresp),
		.o_bvalid(o_bvalid),
		.i_bready(i_bready),
		.i_araddr(i_araddr),
		.i_arvalid(i_arvalid),
		.o_arready(o_arready),
		.o_rdata(o_rdata),
		.o_rresp(o_rresp),
		.o_rvalid(o_rvalid),
		.i_rready(i_rready),
		.o_pwm(o_pwm),
		.o_pwm_n(o_pwm_n),
		.o_irq(o_irq)
	);
	timer_counter_pwm_unit_stage stage (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_hi(o_pwm),
		.i_lo(o_pwm_n),
		.i_trip(trip),
		.o_fault(i_kill),
		.o_shoot(shoot)
	);

	// The 100 MHz clock.
	always #5 i_ref_clk = ~i_ref_clk;

	// Prints the verdict and ends the run.
	task automatic complete_run;
		if (fail_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// One cycle of a bounded wait; running out counts as a failure.
	task automatic tick(inout int n);
		@(negedge i_ref_clk);
		n++;
		if (n > 200) begin
			fail_count++;
			complete_run;
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge i_ref_clk);
	endtask

	// Write: both channels offered together, each dropped once taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = TCP_RESP_OKAY);
		int n;
		logic pa, pw;
		n = 0;
		pa = 1'b1;
		pw = 1'b1;
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		while (pa || pw) begin
			tick(n);
			pa = pa && !o_awready;
			pw = pw && !o_wready;
			@(posedge i_ref_clk);
			i_awvalid <= pa;
			i_wvalid <= pw;
			i_bready <= 1'b1;
		end
		do tick(n); while (!o_bvalid);
		chk(32'(o_bresp), 32'(er));
		@(posedge i_ref_clk);
		i_bready <= 1'b0;
	endtask

	// Read; an unknown expected value means the data is only drained.
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er = TCP_RESP_OKAY);
		int n;
		n = 0;
		i_araddr <= a;
		i_arvalid <= 1'b1;
		do tick(n); while (!o_arready);
		@(posedge i_ref_clk);
		i_arvalid <= 1'b0;
		i_rready <= 1'b1;
		do tick(n); while (!o_rvalid);
		chk(32'(o_rresp), 32'(er));
		if (!$isunknown(e) && er === TCP_RESP_OKAY) chk(o_rdata, e);
		@(posedge i_ref_clk);
		i_rready <= 1'b0;
	endtask

	task automatic irq_is(input logic e);
		repeat (2) @(negedge i_ref_clk);
		chk(32'(o_irq), 32'(e));
		@(posedge i_ref_clk);
	endtask

	// Counts high cycles of each pin over a window of k cycles.
	task automatic duty(input int k, input int eh, input int el);
		int h, l;
		h = 0;
		l = 0;
		repeat (k) begin
			@(negedge i_ref_clk);
			h += int'(o_pwm);
			l += int'(o_pwm_n);
		end
		@(posedge i_ref_clk);
		chk(32'(h), 32'(eh));
		chk(32'(l), 32'(el));
	endtask

	initial begin
		repeat (12) @(posedge i_ref_clk);
		i_resetn <= 1'b1;
		@(posedge i_ref_clk);
		// Reset contents, then an unmapped place on both paths.
		for (int i = 0; i < 9; i++) begin
			rd(8'(4 * i), (i == 1) ? 32'h0000_FFFF : 32'h0000_0000);
		end
		rd(8'h24, 32'hxxxx_xxxx, TCP_RESP_SLVERR);
		wr(8'h24, 32'h0000_0001, TCP_RESP_SLVERR);
		// Free-running PWM, dead-band and the terminal count interrupt.
		wr(TCP_PERIOD_OFS, PER);
		wr(TCP_CMP0_OFS, C0);
		wr(TCP_CMP1_OFS, C1);
		wr(TCP_DEAD_OFS, DB);
		wr(TCP_MASK_OFS, 32'h0000_0001);
		wr(TCP_CTRL_OFS, 32'h0000_0021);
		cyc(40);
		duty(10 * (PER + 1), 10 * TH, 10 * CH);
		irq_is(1'b1);
		wr(TCP_MASK_OFS, 32'h0000_0000);
		irq_is(1'b0);
		// Clock enable low freezes the pins although the counter would otherwise run.
		i_ce <= 1'b0;
		@(negedge i_ref_clk);
		held = {o_pwm, o_pwm_n};
		cyc(2 * (PER + 1));
		@(negedge i_ref_clk);
		chk(32'({o_pwm, o_pwm_n}), 32'(held));
		@(posedge i_ref_clk);
		i_ce <= 1'b1;
		// One-shot run stops at the period value and holds it.
		wr(TCP_CTRL_OFS, 32'h0000_0023);
		cyc(3 * PER);
		rd(TCP_COUNT_OFS, PER);
		rd(TCP_STAT_OFS, 32'h0000_0003);
		// A capture pulse copies the held count and raises its flag.
		wr(TCP_CTRL_OFS, 32'h0000_0013);
		wr(TCP_MASK_OFS, 32'h0000_0004);
		irq_is(1'b0);
		i_capture <= 1'b1;
		cyc(4);
		i_capture <= 1'b0;
		cyc(6);
		irq_is(1'b1);
		rd(TCP_CAPT_OFS, PER);
		rd(TCP_STAT_OFS, 32'h0000_0004);
		irq_is(1'b0);
		// A trip forces each configured kill level while the counter runs.
		wr(TCP_CTRL_OFS, 32'h0000_0025);
		trip <= 1'b1;
		cyc(8);
		duty(10, 10, 0);
		trip <= 1'b0;
		cyc(10);
		wr(TCP_CTRL_OFS, 32'h0000_0009);
		trip <= 1'b1;
		cyc(8);
		duty(10, 0, 10);
		rd(TCP_STAT_OFS, 32'h0000_000B);
		trip <= 1'b0;
		cyc(20);
		chk(32'(shoot), 32'h0000_0000);
		complete_run;
	end
endmodule

bind timer_counter_pwm_unit_unit timer_counter_pwm_unit_checker watch (
	.i_ref_clk(i_ref_clk),
	.i_resetn(i_resetn),
	.i_kill(i_kill),
	.i_awvalid(i_awvalid),
	.o_awready(o_awready),
	.o_bresp(o_bresp),
	.o_bvalid(o_bvalid),
	.i_bready(i_bready),
	.i_arvalid(i_arvalid),
	.o_arready(o_arready),
	.o_rdata(o_rdata),
	.o_rvalid(o_rvalid),
	.i_rready(i_rready),
	.o_pwm(o_pwm),
	.o_pwm_n(o_pwm_n)
);
